// >>> include/tec_pkg.sv
// Constants, field layouts and types for the 16-bit timer/event counter.
// Assumes a byte-wide register port driven by the core.
package tec_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TEC_ADDR_COUNT_HIGH  = 8'h20;
    localparam logic [7:0] TEC_ADDR_COUNT_LOW   = 8'h21;
    localparam logic [7:0] TEC_ADDR_CONTROL     = 8'h22;
    localparam logic [7:0] TEC_ADDR_RELOAD_HIGH = 8'h23;
    localparam logic [7:0] TEC_ADDR_RELOAD_LOW  = 8'h24;
    localparam logic [7:0] TEC_ADDR_CONVERTER   = 8'h25;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         TEC_CTRL_EDGE_POS    = 3;
    localparam int         TEC_CTRL_RUN_POS     = 4;
    localparam int         TEC_CTRL_MODE_POS    = 5;
    localparam int         TEC_CONV_SELECT_POS  = 1;
    localparam int         TEC_CONV_OSC_POS     = 4;
    localparam logic [7:0] TEC_CTRL_RESET       = 8'h08;
    localparam logic [7:0] TEC_CONV_RESET       = 8'h80;
    localparam logic [7:0] TEC_CTRL_READ_MASK   = 8'hF8;
    localparam logic [7:0] TEC_CONV_READ_MASK   = 8'hF3;
    localparam logic [15:0] TEC_COUNT_RESET     = 16'h0000;
    localparam logic [15:0] TEC_COUNT_MAX       = 16'hFFFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         TEC_PRESCALE_DIV     = 4;
    localparam logic [1:0] TEC_PRESCALE_LAST    = 2'(TEC_PRESCALE_DIV - 1);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TEC_MODE_SYSCLK   = 3'b000,
        TEC_MODE_SYSCLK4  = 3'b001,
        TEC_MODE_RTC      = 3'b010,
        TEC_MODE_ADCLK    = 3'b011,
        TEC_MODE_EVENT    = 3'b100,
        TEC_MODE_PULSE    = 3'b101,
        TEC_MODE_UNUSED6  = 3'b110,
        TEC_MODE_UNUSED7  = 3'b111
    } tec_mode_type;

    typedef enum logic [1:0] {
        TEC_PW_IDLE    = 2'b00,
        TEC_PW_ARMED   = 2'b01,
        TEC_PW_MEASURE = 2'b10
    } tec_pw_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr_en;
        logic       rd_en;
        logic [7:0] wdata;
    } tec_bus_type;

    typedef struct packed {
        logic port_a_bit3_latch;
        logic div_freq_option;
        logic counter_interrupt_enable;
        logic flag_clear;
    } tec_sys_type;

endpackage

// >>> logic/tec_timer_event_counter.sv
// 16-bit up-counting timer/event counter with preload and divided-frequency output.
// Assumes all inputs are synchronous to clk and the byte port is driven by the core.
//
// Overview of operation
// - Select bit zero makes one 16-bit counter.
// - Preload low write buffers; high write commits both.
// - High read latches low; low read returns buffer.
// - Mode field picks clock source or measurement.
// - Mode in bits 5-7; bit 3 edge.
// - Bit 4 run control enables counting.
// - Control bits 0-2 read as zero.
// - Event mode counts selected external input edges.
// - Count up; overflow reloads, sets request flag.
// - Pulse mode times input level, then stops.
// - Edge started, one measurement per run setting.
// - Pulse mode overflow reloads and requests too.
// - Other modes never clear run bit themselves.
// - Overflow wakes halt; may drive port pin.
// - Interrupt enable zero blocks overflow service.
// - Latch clear enables output; set holds low.
// - Stopped preload write also loads the counter.
// - High byte read blocks the count clock.
// - Counter bytes inaccessible while counting runs.
// - Converter mode bits select the A/D oscillation.
`timescale 1ns/1ps

module tec_timer_event_counter #(
    parameter int COUNT_WIDTH = 16,
    parameter int OSC_INPUTS  = 8
) (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire tec_pkg::tec_bus_type      bus,
    output      logic [7:0]                rdata,
    input  wire tec_pkg::tec_sys_type      sys,
    input  wire logic                      external_count_input,
    input  wire logic                      rtc_tick,
    input  wire logic [OSC_INPUTS-1:0]     ad_osc_in,
    output      logic                      overflow_request_flag,
    output      logic                      interrupt_request,
    output      logic                      wake_up,
    output      logic                      port_a_bit3
);
    import tec_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [COUNT_WIDTH-1:0] counter;
    logic [COUNT_WIDTH-1:0] preload;
    logic [7:0]             low_byte_buffer;
    logic [7:0]             control;
    logic [7:0]             converter_control;
    logic [1:0]             prescale;
    logic                   ext_prev;
    logic                   rtc_prev;
    logic                   osc_prev;
    logic                   div_freq_toggle;
    logic                   overflow_pulse;
    tec_pw_state_type       pw_state;
    tec_pw_state_type       next_pw_state;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
        hit = (a == ref_addr);
    endfunction

    function automatic logic [15:0] join_bytes(input logic [7:0] high, input logic [7:0] low);
        join_bytes = {high, low};
    endfunction

    function automatic logic [7:0] guard(input logic blocked, input logic [7:0] value);
        guard = blocked ? 8'h00 : value;
    endfunction

    wire tec_mode_type mode         = tec_mode_type'(control[TEC_CTRL_MODE_POS +: 3]);
    wire logic         run_bit      = control[TEC_CTRL_RUN_POS];
    wire logic         active_edge_select = control[TEC_CTRL_EDGE_POS];
    wire logic         converter_or_timer_select = converter_control[TEC_CONV_SELECT_POS];
    wire logic [3:0]   osc_mode     = converter_control[TEC_CONV_OSC_POS +: 4];

    wire logic locked      = run_bit;
    wire logic timer_form  = !converter_or_timer_select;
    wire logic wr_ctrl     = bus.wr_en && hit(bus.addr, TEC_ADDR_CONTROL);
    wire logic wr_conv     = bus.wr_en && hit(bus.addr, TEC_ADDR_CONVERTER);
    wire logic wr_cnt_hi   = bus.wr_en && !locked && hit(bus.addr, TEC_ADDR_COUNT_HIGH);
    wire logic wr_cnt_lo   = bus.wr_en && !locked && hit(bus.addr, TEC_ADDR_COUNT_LOW);
    wire logic wr_pre_hi   = bus.wr_en && !locked && hit(bus.addr, TEC_ADDR_RELOAD_HIGH);
    wire logic wr_pre_lo   = bus.wr_en && !locked && hit(bus.addr, TEC_ADDR_RELOAD_LOW);
    wire logic rd_cnt_hi   = bus.rd_en && !locked && hit(bus.addr, TEC_ADDR_COUNT_HIGH);
    wire logic rd_cnt_any  = bus.rd_en && hit(bus.addr, TEC_ADDR_COUNT_HIGH);
    wire logic counter_commit = wr_pre_hi || wr_cnt_hi;
    wire logic [15:0] commit_word = join_bytes(bus.wdata, low_byte_buffer);

    // ------------------------------------------------------------
    // Count clock sources
    // ------------------------------------------------------------
    wire logic tick4       = (prescale == TEC_PRESCALE_LAST);
    wire logic rtc_rise    = rtc_tick && !rtc_prev;
    wire logic osc_sel     = !osc_mode[3] && ad_osc_in[osc_mode[2:0]];
    wire logic osc_rise    = osc_sel && !osc_prev;
    wire logic ext_rise    = external_count_input && !ext_prev;
    wire logic ext_fall    = !external_count_input && ext_prev;
    wire logic ext_active  = active_edge_select ? ext_fall : ext_rise;
    wire logic pw_start    = active_edge_select ? ext_rise : ext_fall;
    wire logic pw_end      = active_edge_select ? ext_fall : ext_rise;
    wire logic pulse_mode  = (mode == TEC_MODE_PULSE);
    wire logic measuring   = (pw_state == TEC_PW_MEASURE);

    logic source_tick;
    always_comb begin
        case (mode)
            TEC_MODE_SYSCLK:  source_tick = 1'b1;
            TEC_MODE_SYSCLK4: source_tick = tick4;
            TEC_MODE_RTC:     source_tick = rtc_rise;
            TEC_MODE_ADCLK:   source_tick = osc_rise;
            TEC_MODE_EVENT:   source_tick = ext_active;
            TEC_MODE_PULSE:   source_tick = tick4 && measuring;
            default:          source_tick = 1'b0;
        endcase
    end

    wire logic count_tick = run_bit && timer_form && source_tick && !rd_cnt_any;
    wire logic overflow   = count_tick && (counter == TEC_COUNT_MAX);
    wire logic pw_done    = run_bit && pulse_mode && measuring && pw_end;

    // ------------------------------------------------------------
    // Pulse width measurement sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_pw_state = pw_state;
        case (pw_state)
            TEC_PW_IDLE: begin
                if (run_bit && timer_form && pulse_mode) begin
                    next_pw_state = TEC_PW_ARMED;
                end
            end
            TEC_PW_ARMED: begin
                if (pw_start) begin
                    next_pw_state = TEC_PW_MEASURE;
                end
            end
            TEC_PW_MEASURE: begin
                if (pw_end) begin
                    next_pw_state = TEC_PW_IDLE;
                end
            end
            default: next_pw_state = TEC_PW_IDLE;
        endcase
        if (!run_bit || !pulse_mode || !timer_form) begin
            next_pw_state = TEC_PW_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pw_state <= TEC_PW_IDLE;
        end else begin
            pw_state <= next_pw_state;
        end
    end

    // ------------------------------------------------------------
    // Edge history and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= 2'h0;
            ext_prev <= 1'b0;
            rtc_prev <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            prescale <= prescale + 2'h1;
            ext_prev <= external_count_input;
            rtc_prev <= rtc_tick;
            osc_prev <= osc_sel;
        end
    end

    // ------------------------------------------------------------
    // Control and converter registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control <= TEC_CTRL_RESET;
        end else if (wr_ctrl) begin
            control <= bus.wdata & TEC_CTRL_READ_MASK;
        end else if (pw_done) begin
            control[TEC_CTRL_RUN_POS] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            converter_control <= TEC_CONV_RESET;
        end else if (wr_conv) begin
            converter_control <= bus.wdata & TEC_CONV_READ_MASK;
        end
    end

    // ------------------------------------------------------------
    // Counter, preload and shared low byte buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_byte_buffer <= 8'h00;
        end else if (wr_cnt_lo || wr_pre_lo) begin
            low_byte_buffer <= bus.wdata;
        end else if (rd_cnt_hi) begin
            low_byte_buffer <= counter[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preload <= TEC_COUNT_RESET;
        end else if (wr_pre_hi) begin
            preload <= commit_word;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter <= TEC_COUNT_RESET;
        end else if (counter_commit) begin
            counter <= commit_word;
        end else if (overflow) begin
            counter <= preload;
        end else if (count_tick) begin
            counter <= counter + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] read_mux;
    always_comb begin
        read_mux = 8'h00;
        case (bus.addr)
            TEC_ADDR_COUNT_HIGH:  read_mux = guard(locked, counter[15:8]);
            TEC_ADDR_COUNT_LOW:   read_mux = guard(locked, low_byte_buffer);
            TEC_ADDR_CONTROL:     read_mux = control & TEC_CTRL_READ_MASK;
            TEC_ADDR_RELOAD_HIGH: read_mux = guard(locked, preload[15:8]);
            TEC_ADDR_RELOAD_LOW:  read_mux = guard(locked, preload[7:0]);
            TEC_ADDR_CONVERTER:   read_mux = converter_control & TEC_CONV_READ_MASK;
            default:              read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (bus.rd_en) begin
            rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag, wake-up and divided-frequency output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overflow_request_flag <= 1'b0;
        end else if (overflow) begin
            overflow_request_flag <= 1'b1;
        end else if (sys.flag_clear) begin
            overflow_request_flag <= 1'b0;
        end
    end

    wire logic div_freq_enabled = sys.div_freq_option && !sys.port_a_bit3_latch;
    wire logic div_freq_next    = div_freq_enabled && (overflow ? !div_freq_toggle : div_freq_toggle);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overflow_pulse  <= 1'b0;
            div_freq_toggle <= 1'b0;
            port_a_bit3     <= 1'b0;
        end else begin
            overflow_pulse <= overflow;
            if (!div_freq_enabled) begin
                div_freq_toggle <= 1'b0;
            end else if (overflow) begin
                div_freq_toggle <= !div_freq_toggle;
            end
            if (sys.div_freq_option) begin
                port_a_bit3 <= div_freq_next;
            end else begin
                port_a_bit3 <= sys.port_a_bit3_latch;
            end
        end
    end

    assign wake_up           = overflow_pulse;
    assign interrupt_request = overflow_request_flag && sys.counter_interrupt_enable;

endmodule

// >>> testbench/tec_event_source.sv
// Behavioural source of events and pulses on the external count pin.
// Assumes one caller at a time; pin idles low between pulses.
`timescale 1ns/1ps

module tec_event_source (
    input  wire logic clk,
    output      logic pin
);
    initial pin = 1'b0;
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge clk) pin <= 1'b1;
            repeat (w) @(posedge clk);
            pin <= 1'b0;
            repeat (w) @(posedge clk);
        end
    endtask
endmodule

// >>> testbench/tec_timer_event_counter_monitor.sv
// Concurrent checks on the timer/event counter ports.
// Assumes it is bound to every tec_timer_event_counter instance.
`timescale 1ns/1ps

module tec_monitor #(
    parameter int COUNT_WIDTH = 16,
    parameter int OSC_INPUTS  = 8
) (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire tec_pkg::tec_bus_type  bus,
    input wire logic [7:0]            rdata,
    input wire tec_pkg::tec_sys_type  sys,
    input wire logic                  external_count_input,
    input wire logic                  rtc_tick,
    input wire logic [OSC_INPUTS-1:0] ad_osc_in,
    input wire logic                  overflow_request_flag,
    input wire logic                  interrupt_request,
    input wire logic                  wake_up,
    input wire logic                  port_a_bit3
);
    import tec_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence ctrl_read;
        bus.rd_en && bus.addr == TEC_ADDR_CONTROL;
    endsequence
    sequence flag_set;
        !overflow_request_flag ##1 overflow_request_flag;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    irq_gate_a: assert property (interrupt_request == (overflow_request_flag && sys.counter_interrupt_enable))
        else $error("interrupt request differs from flag and enable");
    flag_sticky_a: assert property (overflow_request_flag && !sys.flag_clear |=> overflow_request_flag)
        else $error("overflow flag dropped without clear");
    flag_wake_a: assert property (flag_set |-> ##[0:1] wake_up)
        else $error("no wake pulse after overflow");
    wake_cause_a: assert property (wake_up |-> overflow_request_flag || $past(overflow_request_flag))
        else $error("wake pulse without overflow");
    divout_toggle_a: assert property ($past(rstn) && $past(sys.div_freq_option && !sys.port_a_bit3_latch)
        && $rose(overflow_request_flag) |-> port_a_bit3 != $past(port_a_bit3))
        else $error("divided output did not toggle on overflow");
    divout_low_a: assert property ($past(rstn) && $past(sys.div_freq_option && sys.port_a_bit3_latch)
        |-> !port_a_bit3)
        else $error("divided output not held low");
    ctrl_zero_a: assert property (ctrl_read |=> rdata[2:0] == 3'b000)
        else $error("control low bits not zero");
    rdata_hold_a: assert property (!bus.rd_en |=> $stable(rdata))
        else $error("read data changed without read");
endmodule

bind tec_timer_event_counter tec_monitor #(.COUNT_WIDTH(COUNT_WIDTH), .OSC_INPUTS(OSC_INPUTS)) i_mon (
    .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .sys(sys),
    .external_count_input(external_count_input), .rtc_tick(rtc_tick), .ad_osc_in(ad_osc_in),
    .overflow_request_flag(overflow_request_flag), .interrupt_request(interrupt_request),
    .wake_up(wake_up), .port_a_bit3(port_a_bit3));

// >>> testbench/tec_timer_event_counter_tb.sv
// Self-checking bench for the timer/event counter.
// Assumes the monitor binds itself and tec_event_source drives the count pin.
`timescale 1ns/1ps

module tec_timer_event_counter_tb;
    import tec_pkg::*;
    logic        clk;
    logic        rstn;
    tec_bus_type bus;
    tec_sys_type sys;
    logic [7:0]  rdata;
    logic        ext_pin;
    logic [7:0]  slow;
    logic        flag;
    logic        irq;
    logic        pin;
    logic [7:0]  b;
    logic [15:0] v;
    logic [15:0] w;
    logic        p0;
    int          n_errors;
    int          tests_run;
    logic [2:0]  m_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    int          lo_tab [6] = '{36, 8, 3, 8, 0, 0};
    int          hi_tab [6] = '{44, 13, 7, 13, 0, 0};

    tec_timer_event_counter i_dut (
        .clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .sys(sys),
        .external_count_input(ext_pin), .rtc_tick(slow[2]), .ad_osc_in({5'h00, slow[1], 2'h0}),
        .overflow_request_flag(flag), .interrupt_request(irq), .wake_up(), .port_a_bit3(pin));
    tec_event_source i_src (.clk(clk), .pin(ext_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) slow <= slow + 8'h01;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, 1'b1, 1'b0, d};
        @(posedge clk) bus.wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) bus <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk) bus.rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd16(output logic [15:0] d);
        rd(TEC_ADDR_COUNT_HIGH, d[15:8]);
        rd(TEC_ADDR_COUNT_LOW, d[7:0]);
    endtask
    task automatic ld16(input logic [7:0] a, input logic [15:0] d);
        wr(a + 8'h01, d[7:0]);
        wr(a, d[15:8]);
    endtask
    task automatic span(input logic [7:0] c, input int cyc, input int np);
        wr(TEC_ADDR_CONTROL, c);
        if (np > 0) i_src.pulses(np, 3);
        repeat (cyc) @(posedge clk);
        wr(TEC_ADDR_CONTROL, c & 8'hEF);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        bus = '0;
        sys = '{1'b0, 1'b1, 1'b1, 1'b0};
        slow = 8'h00;
        n_errors = 0;
        tests_run = 0;
        rstn = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(TEC_ADDR_CONTROL, b);
        chk("ctrl_reset", 16'(b), 16'h0008);
        wr(TEC_ADDR_CONVERTER, 8'h20);
        rd(TEC_ADDR_CONVERTER, b);
        chk("conv", 16'(b), 16'h0020);
        wr(TEC_ADDR_CONTROL, 8'h0F);
        rd(TEC_ADDR_CONTROL, b);
        chk("ctrl_low", 16'(b), 16'h0008);
        wr(TEC_ADDR_RELOAD_LOW, 8'h18);
        rd(TEC_ADDR_RELOAD_LOW, b);
        chk("buf_only", 16'(b), 16'h0000);
        wr(TEC_ADDR_RELOAD_HIGH, 8'hFC);
        rd16(v);
        chk("stop_load", v, 16'hFC18);
        ld16(TEC_ADDR_COUNT_HIGH, 16'hFFFA);
        rd(TEC_ADDR_RELOAD_LOW, b);
        chk("preload_kept", 16'(b), 16'h0018);
        rd16(v);
        chk("count_load", v, 16'hFFFA);
        p0 = pin;
        wr(TEC_ADDR_CONTROL, 8'h10);
        for (int i = 0; i < 50 && flag !== 1'b1; i++) @(posedge clk);
        #1 chk("irq", 16'({flag, irq}), 16'h0003);
        chk("div_toggle", 16'(pin != p0), 16'h0001);
        rd(TEC_ADDR_COUNT_HIGH, b);
        chk("busy_read", 16'(b), 16'h0000);
        rd(TEC_ADDR_CONTROL, b);
        chk("run_kept", 16'(b), 16'h0010);
        wr(TEC_ADDR_CONTROL, 8'h00);
        rd16(v);
        chk("reload", 16'(v >= 16'hFC18 && v < 16'hFC40), 16'h0001);
        @(posedge clk) sys.counter_interrupt_enable <= 1'b0;
        @(posedge clk);
        #1 chk("irq_off", 16'({flag, irq}), 16'h0002);
        @(posedge clk) sys.flag_clear <= 1'b1;
        sys.port_a_bit3_latch <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("pin_low", 16'({flag, pin}), 16'h0000);
        @(posedge clk) sys.flag_clear <= 1'b0;
        sys.port_a_bit3_latch <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            ld16(TEC_ADDR_COUNT_HIGH, 16'h0000);
            span({m_tab[k], 5'h10}, 40, 0);
            rd16(v);
            chk("mode_rate", 16'(v >= 16'(lo_tab[k]) && v <= 16'(hi_tab[k])), 16'h0001);
        end
        for (int e = 0; e < 2; e++) begin
            ld16(TEC_ADDR_COUNT_HIGH, 16'h0000);
            span({3'b100, 1'b1, e[0], 3'b000}, 4, 5);
            rd16(v);
            chk("events", v, 16'h0005);
        end
        ld16(TEC_ADDR_COUNT_HIGH, 16'h0000);
        wr(TEC_ADDR_CONTROL, 8'hB8);
        i_src.pulses(1, 40);
        rd(TEC_ADDR_CONTROL, b);
        chk("pw_stop", 16'(b), 16'h00A8);
        rd16(v);
        chk("pw_width", 16'(v >= 16'h0008 && v <= 16'h000C), 16'h0001);
        i_src.pulses(1, 20);
        rd16(w);
        chk("pw_once", w, v);
        @(posedge clk) sys.flag_clear <= 1'b1;
        @(posedge clk) sys.flag_clear <= 1'b0;
        ld16(TEC_ADDR_COUNT_HIGH, 16'hFFFE);
        wr(TEC_ADDR_CONTROL, 8'hB8);
        i_src.pulses(1, 40);
        rd16(v);
        chk("pw_overflow", 16'({flag, 7'h00, v[15:8]}), 16'h80FC);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule
